//--- hdl/mdmrs_core.sv
// Purpose: data memory, pointers, accumulator, ALU and return stack control
// Assumes: sequencer gives one-cycle op, call and return pulses
// Notes:   APB word at byte address 4*index; peripheral specials read zero here
`timescale 1ns/1ps
`default_nettype none
module mdmrs_core
  import mdmrs_pkg::*;
(
  input wire logic i_clock,                   // 10 MHz system clock
  input wire logic i_rst_n,                   // sync reset, active low
  input wire logic i_psel,                    // APB select
  input wire logic i_penable,                 // APB enable
  input wire logic i_pwrite,                  // APB write
  input wire logic [mdmrs_pkg::APB_AW-1:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata,           // APB write data
  output logic [31:0] o_prdata,               // APB read data
  output logic o_pready,                      // APB ready
  output logic o_pslverr,                     // APB error
  input wire logic i_call,                    // call pulse
  input wire logic i_ret,                     // return pulse
  input wire logic i_irq_event,               // enabled interrupt raised
  input wire logic [mdmrs_pkg::PC_W-1:0] i_pc, // counter to save
  output logic o_irq_ack,                     // acknowledge pulse
  output logic o_irq_pending,                 // latched request
  output logic [mdmrs_pkg::PC_W-1:0] o_ret_pc, // restored counter
  output logic o_stack_full,                  // stack full
  input wire logic i_op_valid,                // op strobe
  input wire mdmrs_pkg::mdmrs_op_e i_op,       // operation
  input wire logic [7:0] i_op_addr,           // memory operand index
  input wire logic i_op_to_acc,               // result to accumulator
  input wire logic i_op_imm_en,               // use immediate operand
  input wire logic [7:0] i_op_imm,            // immediate operand
  input wire logic [2:0] i_op_bit,            // bit number
  output logic [7:0] o_op_result,             // last result
  output logic o_op_skip                      // skip next instruction
);
  import mdmrs_pkg::*;

  logic [7:0] ram [RAM_WORDS];
  logic [7:0] ptr_a;
  logic [7:0] ptr_b;
  logic [7:0] bank;
  logic [7:0] acc;
  logic [7:0] flags;
  logic pending;
  logic rd_ok;
  mdmrs_stack_if stk ();

  // ************************************************************
  // address helpers
  // ************************************************************
  // indirect through pointer; bit 8 = usable
  // pointer at an indirect location is unusable
  // full 8-bit pointer value as address
  function automatic logic [8:0] resolve(input logic [7:0] a, input logic [7:0] pa, input logic [7:0] pb);
    logic [7:0] e;
    e = (a == ADDR_IND_A) ? pa : (a == ADDR_IND_B) ? pb : a;
    resolve = {!(e == ADDR_IND_A || e == ADDR_IND_B), e};
  endfunction

  function automatic logic is_ram(input logic [7:0] e, input logic [7:0] bk);
    is_ram = (e >= RAM_BASE) && (bk == BANK_ZERO);
  endfunction

  function automatic logic [7:0] rd_loc(input logic [8:0] r);
    logic [7:0] e;
    e = r[7:0];
    rd_loc = RST_BYTE;
    if (r[8]) begin
      if (is_ram(e, bank)) begin
        rd_loc = ram[e - RAM_BASE];
      end else begin
        case (e)
          ADDR_PTR_A: rd_loc = ptr_a;
          ADDR_PTR_B: rd_loc = ptr_b;
          ADDR_BANK: rd_loc = bank;
          ADDR_ACC: rd_loc = acc;
          ADDR_FLAGS: rd_loc = flags & FLAGS_WMASK;
          default: rd_loc = RST_BYTE;
        endcase
      end
    end
  endfunction

  // ************************************************************
  // ALU
  // ************************************************************
  logic [8:0] op_dst;
  logic [7:0] op_mem;
  logic [7:0] op_b;
  logic [7:0] res;
  logic [7:0] next_flags;
  logic upd_flags;
  logic wr_res;
  logic next_skip;
  logic [7:0] bb;
  logic cin;
  logic [8:0] sum;
  logic [4:0] lo;
  logic [8:0] daa;

  assign op_dst = resolve(i_op_to_acc ? ADDR_ACC : i_op_addr, ptr_a, ptr_b);
  // a process, so a changed stored value retriggers the read, not only a new address
  always_comb begin
    op_mem = rd_loc(resolve(i_op_addr, ptr_a, ptr_b));
  end
  assign op_b = i_op_imm_en ? i_op_imm : op_mem;

  always_comb begin
    res = RST_BYTE;
    next_flags = flags & FLAGS_WMASK;
    upd_flags = 1'b1;
    wr_res = 1'b1;
    next_skip = 1'b0;
    bb = op_b;
    cin = 1'b0;
    if (i_op == OP_SUB || i_op == OP_SBC) begin
      bb = ~op_b;
    end
    case (i_op)
      OP_ADC, OP_SBC: cin = flags[FLAG_C];
      OP_SUB: cin = 1'b1;
      default: cin = 1'b0;
    endcase
    sum = {1'b0, acc} + {1'b0, bb} + {8'h00, cin};
    lo = {1'b0, acc[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    daa = {1'b0, acc};
    if (acc[3:0] > 4'h9 || flags[FLAG_AC]) begin
      daa = daa + 9'h006;
    end
    if (daa[8:4] > 5'h09 || flags[FLAG_C]) begin
      daa = daa + 9'h060;
    end
    case (i_op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        res = sum[7:0];
        next_flags[FLAG_C] = sum[8];
        next_flags[FLAG_AC] = lo[4];
        // overflow = carry into msb xor carry out
        next_flags[FLAG_OV] = (acc[7] ^ bb[7] ^ sum[7]) ^ sum[8];
      end
      OP_DAA: begin
        res = daa[7:0];
        next_flags[FLAG_C] = daa[8] | flags[FLAG_C];
      end
      OP_AND: res = acc & op_b;
      OP_OR: res = acc | op_b;
      OP_XOR: res = acc ^ op_b;
      OP_CPL: res = ~op_mem;
      OP_RL: res = {op_mem[6:0], op_mem[7]};
      OP_RR: res = {op_mem[0], op_mem[7:1]};
      OP_RLC: begin
        res = {op_mem[6:0], flags[FLAG_C]};
        next_flags[FLAG_C] = op_mem[7];
      end
      OP_RRC: begin
        res = {flags[FLAG_C], op_mem[7:1]};
        next_flags[FLAG_C] = op_mem[0];
      end
      OP_INC, OP_SIZ: res = op_mem + 8'h01;
      OP_DEC, OP_SDZ: res = op_mem - 8'h01;
      OP_SZ, OP_SNZ: begin
        res = op_mem;
        wr_res = 1'b0;
      end
      OP_SET: begin
        res = op_mem | (8'h01 << i_op_bit);
        upd_flags = 1'b0;
      end
      OP_CLR: begin
        res = op_mem & ~(8'h01 << i_op_bit);
        upd_flags = 1'b0;
      end
      OP_MOVA: begin
        res = op_b;
        upd_flags = 1'b0;
      end
      OP_MOVM: begin
        res = acc;
        upd_flags = 1'b0;
      end
      default: begin
        wr_res = 1'b0;
        upd_flags = 1'b0;
      end
    endcase
    // zero flag on logic and arithmetic results
    if (upd_flags && i_op != OP_RL && i_op != OP_RR && i_op != OP_RLC && i_op != OP_RRC) begin
      next_flags[FLAG_Z] = (res == RST_BYTE);
    end
    case (i_op)
      OP_SZ, OP_SIZ, OP_SDZ: next_skip = (res == RST_BYTE);
      OP_SNZ: next_skip = (res != RST_BYTE);
      default: next_skip = 1'b0;
    endcase
  end

  // ************************************************************
  // shared write port: sequencer first, APB when idle
  // ************************************************************
  logic [8:0] apb_loc;
  logic apb_go;
  logic wr_en;
  logic [8:0] wr_loc;
  logic [7:0] wr_data;
  logic op_go;
  logic op_dst_acc;

  assign op_go = i_op_valid && i_op != OP_NOP;
  assign op_dst_acc = (i_op == OP_MOVA) || i_op_to_acc;
  assign apb_loc = resolve(i_paddr[9:2], ptr_a, ptr_b);
  assign o_pslverr = o_pready && (i_paddr[11:10] != 2'b00 || i_paddr[1:0] != 2'b00);
  assign apb_go = o_pready && i_pwrite && !o_pslverr;
  always_comb begin
    wr_en = 1'b0;
    wr_loc = '0;
    wr_data = RST_BYTE;
    if (op_go) begin
      wr_en = wr_res;
      wr_loc = op_dst_acc ? {1'b1, ADDR_ACC} : op_dst;
      wr_data = res;
    end else if (apb_go) begin
      wr_en = 1'b1;
      wr_loc = apb_loc;
      wr_data = i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (wr_en && wr_loc[8] && is_ram(wr_loc[7:0], bank)) begin
      ram[wr_loc[7:0] - RAM_BASE] <= wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ptr_a <= RST_BYTE;
      ptr_b <= RST_BYTE;
      bank <= BANK_ZERO;
      acc <= RST_BYTE;
    end else if (wr_en && wr_loc[8]) begin
      case (wr_loc[7:0])
        ADDR_PTR_A: ptr_a <= wr_data;
        ADDR_PTR_B: ptr_b <= wr_data;
        ADDR_BANK: bank <= wr_data;
        ADDR_ACC: acc <= wr_data;
        default: ;
      endcase
    end
  end

  // flag update beats a plain write to the flags
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      flags <= RST_BYTE;
    end else if (op_go && upd_flags) begin
      flags <= next_flags & FLAGS_WMASK;
    end else if (wr_en && wr_loc == {1'b1, ADDR_FLAGS}) begin
      flags <= wr_data & FLAGS_WMASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_op_result <= RST_BYTE;
      o_op_skip <= 1'b0;
    end else begin
      o_op_skip <= op_go && next_skip;
      if (op_go) begin
        o_op_result <= res;
      end
    end
  end

  // ************************************************************
  // APB slave: data sampled a cycle ahead, ready when no op collides
  // ************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rd_ok <= 1'b0;
      o_prdata <= '0;
    end else begin
      rd_ok <= i_psel && !i_op_valid;
      o_prdata <= {24'h000000, rd_loc(apb_loc)};
    end
  end
  assign o_pready = i_psel && i_penable && rd_ok && !i_op_valid;

  // ************************************************************
  // return stack control
  // ************************************************************
  // request latched; set wins over clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pending <= 1'b0;
    end else if (i_irq_event) begin
      pending <= 1'b1;
    end else if (o_irq_ack) begin
      pending <= 1'b0;
    end
  end
  // no acknowledge while full; a call or a return wins the cycle
  assign o_irq_ack = pending && !stk.full && !i_call && !i_ret;
  assign o_irq_pending = pending;
  assign o_stack_full = stk.full;
  // stack only reachable from the sequencer
  assign stk.push = i_call || o_irq_ack;
  assign stk.pop = i_ret;
  assign stk.push_pc = i_pc;
  assign o_ret_pc = stk.pop_pc;

  mdmrs_stack u_stack (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .s(stk)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  ack_withheld_a: assert property (stk.full |-> !o_irq_ack)
    else $error("acknowledge given on full stack");
  ack_after_ret_a: assert property (pending && stk.full && i_ret && !i_irq_event
    ##1 !i_call && !i_ret |-> o_irq_ack)
    else $error("interrupt not serviced after return");
  reserved_zero_a: assert property (o_pready && !i_pwrite && !o_pslverr && i_paddr[9:2] > ADDR_FLAGS
    && i_paddr[9:2] < RAM_BASE |-> o_prdata == 32'h00000000)
    else $error("reserved location not zero");
  self_ind_a: assert property (op_go && i_op == OP_MOVA && !i_op_imm_en && i_op_addr == ADDR_IND_A
    && ptr_a == ADDR_IND_B |=> acc == RST_BYTE)
    else $error("indirect self access not zero");
  acc_write_a: assert property (apb_go && !op_go && i_paddr[9:2] == ADDR_ACC
    |=> acc == $past(i_pwdata[7:0]))
    else $error("accumulator write lost");
  zero_flag_a: assert property (op_go && i_op == OP_AND && i_op_to_acc && (acc & op_b) == RST_BYTE
    |=> flags[FLAG_Z] && acc == RST_BYTE)
    else $error("zero flag not set");
  add_carry_a: assert property (op_go && i_op == OP_ADD && i_op_to_acc && sum[8]
    |=> flags[FLAG_C] && acc == $past(sum[7:0]))
    else $error("add result or carry wrong");
  ram_store_a: assert property (apb_go && !op_go && apb_loc[8] && is_ram(apb_loc[7:0], bank)
    |=> rd_loc({1'b1, $past(apb_loc[7:0])}) == $past(i_pwdata[7:0]))
    else $error("RAM readback wrong");

  call_full_c: cover property (i_call && stk.full);
  ack_c: cover property (o_irq_ack);
  indirect_c: cover property (op_go && i_op_addr == ADDR_IND_B);
  apb_read_c: cover property (o_pready && !i_pwrite);
endmodule // mdmrs_core
`default_nettype wire

//--- hdl/mdmrs_pkg.sv
// Purpose: shared constants and types of the core data memory and return stack
// Assumes: 8-bit data path, 12-bit program counter
// Notes:   data addresses are register indices; the APB byte address is four times the index
`default_nettype none
package mdmrs_pkg;
  // ************************************************************
  // sizes
  // ************************************************************
  localparam int PC_W = 12;
  localparam int STK_DEPTH = 16;
  localparam int STK_IDX_W = 4;
  localparam int RAM_WORDS = 192;
  localparam int APB_AW = 12;
  // ************************************************************
  // data memory map (register index)
  // ************************************************************
  localparam logic [7:0] ADDR_IND_A = 8'h00;
  localparam logic [7:0] ADDR_PTR_A = 8'h01;
  localparam logic [7:0] ADDR_IND_B = 8'h02;
  localparam logic [7:0] ADDR_PTR_B = 8'h03;
  localparam logic [7:0] ADDR_BANK = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h05;
  localparam logic [7:0] ADDR_FLAGS = 8'h0A;
  localparam logic [7:0] RAM_BASE = 8'h40;
  localparam logic [7:0] RAM_LAST = 8'hFF;
  // ************************************************************
  // flag layout and reset values
  // ************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam logic [7:0] FLAGS_WMASK = 8'h0F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BANK_ZERO = 8'h00;
  localparam logic [STK_IDX_W-1:0] STK_IDX_RST = 4'h0;
  localparam logic [STK_IDX_W:0] STK_CNT_RST = 5'h00;
  localparam logic [STK_IDX_W:0] STK_CNT_FULL = 5'h10;
  // ************************************************************
  // operations issued by the sequencer
  // ************************************************************
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA,
    OP_AND, OP_OR, OP_XOR, OP_CPL,
    OP_RL, OP_RR, OP_RLC, OP_RRC, OP_INC, OP_DEC,
    OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ,
    OP_SET, OP_CLR, OP_MOVA, OP_MOVM
  } mdmrs_op_e;
endpackage
`default_nettype wire

//--- hdl/mdmrs_stack_if.sv
// Purpose: carries push/pop requests between core and return stack
// Assumes: single clock, requests are one-cycle pulses
// Notes:   no clocking block; purely a bundle
`timescale 1ns/1ps
`default_nettype none
interface mdmrs_stack_if;
  import mdmrs_pkg::*;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_pc;
  logic [PC_W-1:0] pop_pc;
  logic full;
  logic empty;
  modport core (output push, output pop, output push_pc, input pop_pc, input full, input empty);
  modport stack (input push, input pop, input push_pc, output pop_pc, output full, output empty);
endinterface
`default_nettype wire

//--- hdl/mdmrs_stack.sv
// Purpose: 16-level program counter return stack
// Assumes: push and pop never in the same cycle
// Notes:   circular index; pop result registered
`timescale 1ns/1ps
`default_nettype none
module mdmrs_stack
  import mdmrs_pkg::*;
(
  input wire logic i_clock,   // system clock
  input wire logic i_rst_n,   // sync reset, active low
  mdmrs_stack_if.stack s      // push/pop bundle
);
  logic [PC_W-1:0] slot [STK_DEPTH];
  logic [STK_IDX_W-1:0] idx;
  logic [STK_IDX_W:0] cnt;
  logic [PC_W-1:0] pop_pc;
  logic [STK_IDX_W-1:0] top;

  assign top = idx - 4'h1;
  assign s.full = (cnt == STK_CNT_FULL);
  assign s.empty = (cnt == STK_CNT_RST);
  assign s.pop_pc = pop_pc;

  // ************************************************************
  // index and count
  // ************************************************************
  // empty after reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      idx <= STK_IDX_RST;
      cnt <= STK_CNT_RST;
    end else if (s.push) begin
      idx <= idx + 4'h1;
      if (!s.full) begin
        cnt <= cnt + 5'h01;
      end
    end else if (s.pop && !s.empty) begin
      idx <= top;
      cnt <= cnt - 5'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (s.push) begin
      slot[idx] <= s.push_pc;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pop_pc <= '0;
    end else if (s.pop && !s.empty) begin
      pop_pc <= slot[top];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  push_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s.push && !s.full |=> cnt == $past(cnt) + 5'h01)
    else $error("push did not grow stack");
  full_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s.push && s.full |=> s.full && idx == $past(idx) + 4'h1)
    else $error("full push broke stack");
  pop_value_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s.pop && !s.empty |=> pop_pc == $past(slot[top]))
    else $error("pop returned wrong counter");
  full_push_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) s.push && s.full);
endmodule // mdmrs_stack
`default_nettype wire

//--- testbench/mdmrs_seq_model.sv
// Purpose: sequencer stand-in issuing calls, returns, interrupt events and ALU ops
// Assumes: one request per task, every pulse one cycle long
// Notes:   signals change by non-blocking assignment just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module mdmrs_seq_model
  import mdmrs_pkg::*;
(
  input wire logic i_clock,                  // system clock
  output logic o_call,                       // call pulse
  output logic o_ret,                        // return pulse
  output logic o_irq,                        // interrupt event
  output logic [mdmrs_pkg::PC_W-1:0] o_pc,   // counter to save
  output logic o_op_valid,                   // op strobe
  output mdmrs_pkg::mdmrs_op_e o_op,         // operation
  output logic [7:0] o_addr,                 // operand index
  output logic o_to_acc,                     // result to accumulator
  output logic o_imm_en,                     // immediate operand used
  output logic [7:0] o_imm,                  // immediate value
  output logic [2:0] o_bit                   // bit number
);
  // ************************************************************
  // request tasks
  // ************************************************************
  initial begin
    {o_call, o_ret, o_irq, o_op_valid, o_to_acc, o_imm_en} = 6'h00;
    o_pc = 12'h000;
    o_op = OP_NOP;
    o_addr = 8'h00;
    o_imm = 8'h00;
    o_bit = 3'h0;
  end
  // call and return never share a cycle
  task automatic pulse(input logic is_call, input logic is_irq, input logic [PC_W-1:0] pc);
    @(posedge i_clock);
    o_pc <= pc;
    o_call <= is_call;
    o_irq <= is_irq;
    o_ret <= !is_call && !is_irq;
    @(posedge i_clock);
    {o_call, o_irq, o_ret} <= 3'h0;
  endtask
  task automatic issue(input mdmrs_op_e op, input logic [7:0] addr, input logic to_acc,
                       input logic imm_en, input logic [7:0] imm, input logic [2:0] b);
    @(posedge i_clock);
    o_op <= op;
    o_addr <= addr;
    o_to_acc <= to_acc;
    o_imm_en <= imm_en;
    o_imm <= imm;
    o_bit <= b;
    o_op_valid <= 1'b1;
    @(posedge i_clock);
    o_op_valid <= 1'b0;
  endtask
endmodule // mdmrs_seq_model
`default_nettype wire

//--- testbench/tb.sv
// Purpose: self-checking bench for the core data memory and return stack
// Assumes: APB master here, sequencer model at the core side
// Notes:   outputs are sampled at the falling edge; APB answers are taken at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mdmrs_pkg::*;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic call, ret, irq, irq_ack, irq_pending, stack_full, op_valid, to_acc, imm_en, skip;
  logic [PC_W-1:0] pc, ret_pc;
  mdmrs_op_e op;
  logic [7:0] op_addr, imm, result;
  logic [2:0] op_bit;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  mdmrs_core mdmrs_core_i (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_call(call), .i_ret(ret), .i_irq_event(irq), .i_pc(pc),
    .o_irq_ack(irq_ack), .o_irq_pending(irq_pending), .o_ret_pc(ret_pc), .o_stack_full(stack_full),
    .i_op_valid(op_valid), .i_op(op), .i_op_addr(op_addr), .i_op_to_acc(to_acc),
    .i_op_imm_en(imm_en), .i_op_imm(imm), .i_op_bit(op_bit), .o_op_result(result), .o_op_skip(skip));
  mdmrs_seq_model mdmrs_seq_model_i (.i_clock(clock), .o_call(call), .o_ret(ret), .o_irq(irq),
    .o_pc(pc), .o_op_valid(op_valid), .o_op(op), .o_addr(op_addr), .o_to_acc(to_acc),
    .o_imm_en(imm_en), .o_imm(imm), .o_bit(op_bit));
  // ************************************************************
  // shared tasks
  // ************************************************************
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clock);
    penable <= 1'b1;
    // request holds until pready is seen high at a rising edge; only the timeout ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    check(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] rd;
    logic err;
    apb(1'b1, {2'b00, idx, 2'b00}, v, rd, err);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, rd, err);
    check(rd, {24'h000000, exp});
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] rd;
    logic err;
    rdc(ADDR_PTR_A, RST_BYTE);
    rdc(ADDR_BANK, BANK_ZERO);
    rdc(ADDR_ACC, RST_BYTE);
    rdc(ADDR_FLAGS, RST_BYTE);
    wr(8'h07, 8'h5A);
    rdc(8'h07, 8'h00);
    rdc(8'h3F, 8'h00);
    apb(1'b0, 12'h404, 8'h00, rd, err);
    check(err, 1'b1);
    check(stack_full, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_memory();
    wr(RAM_BASE, 8'hA5);
    wr(RAM_LAST, 8'h5A);
    wr(ADDR_PTR_A, RAM_BASE);
    wr(ADDR_PTR_B, RAM_LAST);
    rdc(ADDR_PTR_B, RAM_LAST);
    rdc(ADDR_IND_A, 8'hA5);
    rdc(ADDR_IND_B, 8'h5A);
    wr(ADDR_IND_A, 8'h3C);
    rdc(RAM_BASE, 8'h3C);
    wr(ADDR_PTR_A, ADDR_IND_B);
    rdc(ADDR_IND_A, 8'h00);
    wr(ADDR_IND_A, 8'h77);
    rdc(RAM_LAST, 8'h5A);
    wr(ADDR_BANK, 8'h01);
    rdc(RAM_BASE, 8'h00);
    rdc(ADDR_PTR_B, RAM_LAST);
    wr(ADDR_BANK, BANK_ZERO);
    rdc(RAM_BASE, 8'h3C);
    $display("test memory done");
  endtask
  task automatic t_stack();
    for (int i = 0; i < 17; i++) mdmrs_seq_model_i.pulse(1'b1, 1'b0, 12'h100 + i);
    check(stack_full, 1'b1);
    mdmrs_seq_model_i.pulse(1'b0, 1'b1, 12'hABC);
    @(negedge clock);
    check(irq_pending, 1'b1);
    check(irq_ack, 1'b0);
    mdmrs_seq_model_i.pulse(1'b0, 1'b0, 12'hABC);
    @(negedge clock);
    check(irq_ack, 1'b1);
    check(ret_pc, 12'h110);
    for (int j = 0; j < 17; j++) begin
      mdmrs_seq_model_i.pulse(1'b0, 1'b0, 12'hABC);
      @(negedge clock);
      check(ret_pc, (j == 0) ? 12'hABC : (j == 16) ? 12'h101 : 12'h110 - j);
    end
    check(stack_full, 1'b0);
    $display("test stack done");
  endtask
  task automatic t_alu();
    mdmrs_op_e ops[6] = '{OP_SUB, OP_AND, OP_OR, OP_XOR, OP_RL, OP_RR};
    logic [7:0] exp[6] = '{8'h2D, 8'h0C, 8'h3F, 8'h33, 8'h78, 8'h1E};
    logic [31:0] rd;
    logic err;
    wr(ADDR_ACC, 8'h80);
    mdmrs_seq_model_i.issue(OP_ADD, ADDR_ACC, 1'b1, 1'b1, 8'h80, 3'h0);
    @(negedge clock);
    check(result, 8'h00);
    rdc(ADDR_FLAGS, 8'h0D);
    rdc(ADDR_ACC, 8'h00);
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_ACC, 8'h3C);
      mdmrs_seq_model_i.issue(ops[k], ADDR_ACC, 1'b1, 1'b1, 8'h0F, 3'h0);
      @(negedge clock);
      check(result, exp[k]);
    end
    mdmrs_seq_model_i.issue(OP_MOVA, ADDR_IND_A, 1'b1, 1'b0, 8'h00, 3'h0);
    @(negedge clock);
    check(result, 8'h00);
    rdc(ADDR_ACC, 8'h00);
    mdmrs_seq_model_i.issue(OP_AND, ADDR_ACC, 1'b1, 1'b1, 8'h00, 3'h0);
    rdc(ADDR_FLAGS, 8'h05);
    wr(8'h41, 8'hFF);
    mdmrs_seq_model_i.issue(OP_INC, 8'h41, 1'b0, 1'b0, 8'h00, 3'h0);
    rdc(8'h41, 8'h00);
    apb(1'b0, {2'b00, ADDR_FLAGS, 2'b00}, 8'h00, rd, err);
    check(rd[FLAG_Z], 1'b1);
    mdmrs_seq_model_i.issue(OP_SET, 8'h41, 1'b0, 1'b0, 8'h00, 3'h7);
    rdc(8'h41, 8'h80);
    mdmrs_seq_model_i.issue(OP_SNZ, 8'h41, 1'b0, 1'b0, 8'h00, 3'h0);
    @(negedge clock);
    check(skip, 1'b1);
    mdmrs_seq_model_i.issue(OP_SZ, 8'h41, 1'b0, 1'b0, 8'h00, 3'h0);
    @(negedge clock);
    check(skip, 1'b0);
    mdmrs_seq_model_i.issue(OP_CLR, 8'h41, 1'b0, 1'b0, 8'h00, 3'h7);
    rdc(8'h41, 8'h00);
    $display("test alu done");
  endtask
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_memory();
    t_stack();
    t_alu();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
